// >>> rtl/blr_top.sv
// Boot lock checker, lock and fuse registers on APB, and reset vector selection.
//
// Chosen here: the APB interface to the registers and the address map.
module blr_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [blr_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire blr_pkg::blr_acc_req_t acc_req,
	output blr_pkg::blr_acc_rsp_t acc_rsp,
	input wire logic vectors_in_boot,
	output logic irq_mask,
	input wire logic [blr_pkg::ADDR_W-1:0] boot_start_addr,
	input wire blr_pkg::blr_fuse_t fuses,
	input wire blr_pkg::blr_prog_t ext_prog,
	input wire logic hw_boot_pin,
	output logic [blr_pkg::ADDR_W-1:0] reset_vector,
	output logic reset_vector_valid
);
	blr_pkg::blr_state_t st;
	blr_pkg::blr_state_t next_st;
	logic pin_level;
	logic tgt_app;
	logic exe_app;
	logic pc_app;
	logic app_wr_blk;
	logic app_rd_blk;
	logic app_irq_blk;
	logic boot_wr_blk;
	logic boot_rd_blk;
	logic boot_irq_blk;
	logic store_ok;
	logic load_ok;
	logic take_boot;
	logic apb_access;
	logic apb_write;
	logic mapped;
	logic [31:0] rd_word;

	blr_sync2 u_pin_sync (
		.sys_clk(sys_clk),
		.async_in(hw_boot_pin),
		.sync_out(pin_level)
	);

	// The boundary comes from outside because the section size choice lives elsewhere.
	assign tgt_app = acc_req.target < boot_start_addr;
	assign exe_app = acc_req.pc < boot_start_addr;
	assign pc_app = acc_req.pc < boot_start_addr;

	blr_section_guard u_app_guard (
		.write_lock_bit(st.lock[blr_pkg::LK_APP_WRITE]),
		.read_lock_bit(st.lock[blr_pkg::LK_APP_READ]),
		.target_here(tgt_app),
		.exec_here(exe_app),
		.vectors_elsewhere(vectors_in_boot),
		.write_block(app_wr_blk),
		.read_block(app_rd_blk),
		.irq_block(app_irq_blk)
	);

	blr_section_guard u_boot_guard (
		.write_lock_bit(st.lock[blr_pkg::LK_BOOT_WRITE]),
		.read_lock_bit(st.lock[blr_pkg::LK_BOOT_READ]),
		.target_here(~tgt_app),
		.exec_here(~exe_app),
		.vectors_elsewhere(~vectors_in_boot),
		.write_block(boot_wr_blk),
		.read_block(boot_rd_blk),
		.irq_block(boot_irq_blk)
	);

	// The general lock modes are not inputs here at all, so they cannot gate anything.
	assign store_ok = ~pc_app & ~app_wr_blk & ~boot_wr_blk;
	assign load_ok = ~app_rd_blk & ~boot_rd_blk;

	// The programmed boot reset fuse, or a low pin when its enable fuse is programmed, picks boot.
	assign take_boot = ~fuses.boot_reset_fuse | (~fuses.hw_boot_enable_fuse & ~pin_level);

	assign apb_access = psel & penable;
	assign apb_write = apb_access & pwrite & st.pready;
	assign mapped = (paddr == blr_pkg::OFF_LOCK) | (paddr == blr_pkg::OFF_FUSE) |
		(paddr == blr_pkg::OFF_STATUS) | (paddr == blr_pkg::OFF_VECTOR);

	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr)
			blr_pkg::OFF_LOCK: begin
				rd_word[3:0] = st.lock;
			end
			blr_pkg::OFF_FUSE: begin
				rd_word[blr_pkg::FU_BOOT_RESET] = fuses.boot_reset_fuse;
				rd_word[blr_pkg::FU_HW_BOOT_EN] = fuses.hw_boot_enable_fuse;
				rd_word[blr_pkg::FU_PIN_SEEN] = st.pin_seen;
			end
			blr_pkg::OFF_STATUS: begin
				rd_word[blr_pkg::ST_VEC_BOOT] = st.vec_boot;
				rd_word[blr_pkg::ST_STORE_DENIED] = st.store_denied;
				rd_word[blr_pkg::ST_LOAD_DENIED] = st.load_denied;
				rd_word[blr_pkg::ST_IRQ_MASKED] = st.irq_mask;
				rd_word[blr_pkg::ST_VEC_VALID] = st.vec_valid;
			end
			blr_pkg::OFF_VECTOR: begin
				rd_word[blr_pkg::ADDR_W-1:0] = st.vector;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		// One wait state keeps every APB output straight from a flop.
		if (apb_access & ~st.pready) begin
			next_st.pready = 1'b1;
			next_st.pslverr = ~mapped;
			next_st.prdata = pwrite ? st.prdata : rd_word;
		end
		// Software may only program lock bits; writing a one never unprograms.
		if (apb_write & (paddr == blr_pkg::OFF_LOCK)) begin
			next_st.lock = st.lock & pwdata[3:0];
		end
		// Fuse register writes are dropped: no path from the bus reaches a fuse.
		if (apb_write & (paddr == blr_pkg::OFF_STATUS)) begin
			if (pwdata[blr_pkg::ST_STORE_DENIED]) begin
				next_st.store_denied = 1'b0;
			end
			if (pwdata[blr_pkg::ST_LOAD_DENIED]) begin
				next_st.load_denied = 1'b0;
			end
		end
		if (ext_prog.lock_we) begin
			next_st.lock = next_st.lock & ext_prog.lock_data;
		end
		// Erase wins over a programming attempt in the same cycle.
		if (ext_prog.chip_erase) begin
			next_st.lock = blr_pkg::LOCK_UNPROGRAMMED;
		end
		next_st.rsp.done = acc_req.valid;
		next_st.rsp.grant = acc_req.valid & (acc_req.store ? store_ok : load_ok);
		next_st.rsp.denied = acc_req.valid & (acc_req.store ? ~store_ok : ~load_ok);
		// A denial in the clearing cycle still sets the flag, so no event is lost.
		if (acc_req.valid & acc_req.store & ~store_ok) begin
			next_st.store_denied = 1'b1;
		end
		if (acc_req.valid & ~acc_req.store & ~load_ok) begin
			next_st.load_denied = 1'b1;
		end
		next_st.irq_mask = app_irq_blk | boot_irq_blk;
		// The first clocked cycle after reset release catches the pin and fuses once.
		if (~st.vec_valid) begin
			next_st.vec_valid = 1'b1;
			next_st.pin_seen = pin_level;
			next_st.vec_boot = take_boot;
			next_st.vector = take_boot ? boot_start_addr : blr_pkg::APP_RESET_VECTOR;
		end
	end

	// Lock bits return to unprogrammed on reset as well, since no storage survives here.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= blr_pkg::STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign acc_rsp = st.rsp;
	assign irq_mask = st.irq_mask;
	assign reset_vector = st.vector;
	assign reset_vector_valid = st.vec_valid;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_STORE_FROM_APP: assert property (
		acc_req.valid & acc_req.store & (acc_req.pc < boot_start_addr) |=> acc_rsp.denied
	) else $error("store issued from application code was not denied");

	AST_APP_WRITE_LOCK: assert property (
		acc_req.valid & acc_req.store & (acc_req.target < boot_start_addr) &
		~st.lock[blr_pkg::LK_APP_WRITE] |=> acc_rsp.denied & ~acc_rsp.grant
	) else $error("store into locked application section was granted");

	AST_BOOT_WRITE_LOCK: assert property (
		acc_req.valid & acc_req.store & (acc_req.target >= boot_start_addr) &
		~st.lock[blr_pkg::LK_BOOT_WRITE] |=> acc_rsp.denied & ~acc_rsp.grant
	) else $error("store into locked boot section was granted");

	AST_APP_READ_LOCK: assert property (
		acc_req.valid & ~acc_req.store & (acc_req.target < boot_start_addr) &
		(acc_req.pc >= boot_start_addr) & ~st.lock[blr_pkg::LK_APP_READ] |=> acc_rsp.denied
	) else $error("boot code read a read-locked application section");

	AST_BOOT_READ_LOCK: assert property (
		acc_req.valid & ~acc_req.store & (acc_req.target >= boot_start_addr) &
		(acc_req.pc < boot_start_addr) & ~st.lock[blr_pkg::LK_BOOT_READ] |=> acc_rsp.denied
	) else $error("application code read a read-locked boot section");

	AST_FREE_LOADS: assert property (
		acc_req.valid & ~acc_req.store & (st.lock == blr_pkg::LOCK_UNPROGRAMMED)
		|=> acc_rsp.grant ##1 $past(acc_rsp.done, 1)
	) else $error("load refused with all lock bits unprogrammed");

	AST_FREE_BOOT_STORE: assert property (
		acc_req.valid & acc_req.store & (acc_req.pc >= boot_start_addr) &
		(st.lock == blr_pkg::LOCK_UNPROGRAMMED) |=> acc_rsp.grant
	) else $error("boot store refused with all lock bits unprogrammed");

	AST_LOCK_ONE_WAY: assert property (
		!$past(ext_prog.chip_erase) && !$past(srst) |-> (st.lock & ~$past(st.lock)) == 4'h0
	) else $error("lock bit returned to unprogrammed without chip erase");

	AST_ERASE_RESTORES: assert property (
		ext_prog.chip_erase |=> st.lock == blr_pkg::LOCK_UNPROGRAMMED
	) else $error("chip erase did not restore lock bits");

	AST_IRQ_MASK_APP: assert property (
		~st.lock[blr_pkg::LK_APP_READ] & vectors_in_boot & (acc_req.pc < boot_start_addr)
		|=> irq_mask
	) else $error("interrupts not masked in read-locked application section");

	AST_VECTOR_APP: assert property (
		$rose(reset_vector_valid) & ~st.vec_boot |-> reset_vector == blr_pkg::APP_RESET_VECTOR
	) else $error("application reset vector is not zero");

	AST_VECTOR_STEADY: assert property (
		reset_vector_valid |=> $stable(reset_vector) && reset_vector_valid
	) else $error("reset vector changed after it was taken");

	AST_APB_ONE_WAIT: assert property (
		psel & penable & ~pready |=> pready ##1 ~pready
	) else $error("APB answer did not come after exactly one wait state");

	AST_IRQ_MASK_BOOT: assert property (
		~st.lock[blr_pkg::LK_BOOT_READ] & ~vectors_in_boot & (acc_req.pc >= boot_start_addr)
		|=> irq_mask
	) else $error("interrupts not masked in read-locked boot section");

	AST_IRQ_FREE: assert property (
		(st.lock == blr_pkg::LOCK_UNPROGRAMMED) |=> ~irq_mask
	) else $error("interrupts masked with all lock bits unprogrammed");

	AST_VECTOR_BOOT: assert property (
		$rose(reset_vector_valid) & st.vec_boot |-> reset_vector == boot_start_addr
	) else $error("boot reset vector is not the boot start address");

	AST_PIN_IGNORED: assert property (
		$rose(reset_vector_valid) & $past(fuses.boot_reset_fuse) &
		$past(fuses.hw_boot_enable_fuse) |-> ~st.vec_boot
	) else $error("hardware boot pin used while its enable fuse is unprogrammed");

	AST_PIN_FORCES_BOOT: assert property (
		$rose(reset_vector_valid) & ~$past(fuses.hw_boot_enable_fuse) & ~st.pin_seen
		|-> st.vec_boot
	) else $error("low hardware boot pin did not select the boot vector");

	AST_ONE_ANSWER: assert property (
		acc_req.valid |=> acc_rsp.done & (acc_rsp.grant ^ acc_rsp.denied)
	) else $error("access did not get exactly one answer");

	AST_STORE_STICKY: assert property (
		acc_rsp.denied & $past(acc_req.store) |-> st.store_denied
	) else $error("denied store did not set its sticky flag");

	AST_LOAD_STICKY: assert property (
		acc_rsp.denied & ~$past(acc_req.store) |-> st.load_denied
	) else $error("denied load did not set its sticky flag");

	AST_UNMAPPED_ERROR: assert property (
		psel & penable & ~pready & ~mapped |=> pslverr & pready
	) else $error("unmapped address answered without an error");

	COV_STORE_GRANTED: cover property (acc_rsp.done & acc_rsp.grant & $past(acc_req.store));
	COV_LOAD_DENIED: cover property (acc_rsp.denied & ~$past(acc_req.store));
	COV_BOOT_VECTOR: cover property ($rose(reset_vector_valid) & st.vec_boot);
	COV_ERASE_AFTER_LOCK: cover property ((st.lock != 4'hF) ##1 ext_prog.chip_erase);
endmodule

// >>> rtl/blr_pkg.sv
// Package holding constants, register map and carrier types of the boot lock block.
package blr_pkg;
	localparam int ADDR_W = 16;
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] OFF_LOCK = 8'h00;
	localparam logic [APB_AW-1:0] OFF_FUSE = 8'h04;
	localparam logic [APB_AW-1:0] OFF_STATUS = 8'h08;
	localparam logic [APB_AW-1:0] OFF_VECTOR = 8'h0C;
	localparam int LK_APP_WRITE = 0;
	localparam int LK_APP_READ = 1;
	localparam int LK_BOOT_WRITE = 2;
	localparam int LK_BOOT_READ = 3;
	localparam int FU_BOOT_RESET = 0;
	localparam int FU_HW_BOOT_EN = 1;
	localparam int FU_PIN_SEEN = 2;
	localparam int ST_VEC_BOOT = 0;
	localparam int ST_STORE_DENIED = 1;
	localparam int ST_LOAD_DENIED = 2;
	localparam int ST_IRQ_MASKED = 3;
	localparam int ST_VEC_VALID = 4;
	localparam logic [3:0] LOCK_UNPROGRAMMED = 4'hF;
	localparam logic [ADDR_W-1:0] APP_RESET_VECTOR = 16'h0000;
	localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic store;
		logic [ADDR_W-1:0] target;
		logic [ADDR_W-1:0] pc;
	} blr_acc_req_t;

	typedef struct packed {
		logic done;
		logic grant;
		logic denied;
	} blr_acc_rsp_t;

	typedef struct packed {
		logic lock_we;
		logic [3:0] lock_data;
		logic chip_erase;
	} blr_prog_t;

	typedef struct packed {
		logic boot_reset_fuse;
		logic hw_boot_enable_fuse;
	} blr_fuse_t;

	typedef struct packed {
		logic [3:0] lock;
		logic store_denied;
		logic load_denied;
		logic vec_boot;
		logic vec_valid;
		logic pin_seen;
		logic [ADDR_W-1:0] vector;
		blr_acc_rsp_t rsp;
		logic irq_mask;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} blr_state_t;

	localparam blr_state_t STATE_RESET = '{
		lock: LOCK_UNPROGRAMMED,
		store_denied: 1'b0,
		load_denied: 1'b0,
		vec_boot: 1'b0,
		vec_valid: 1'b0,
		pin_seen: 1'b1,
		vector: APP_RESET_VECTOR,
		rsp: '{done: 1'b0, grant: 1'b0, denied: 1'b0},
		irq_mask: 1'b0,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: PRDATA_RESET
	};
endpackage

// >>> rtl/blr_sync2.sv
// Two-stage synchroniser for a level arriving from a device pin.
module blr_sync2 (
	input wire logic sys_clk,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic meta;
		logic stable;
	} blr_sync_t;

	blr_sync_t st;
	blr_sync_t next_st;

	// No reset here on purpose, so the pin level is already valid when reset ends.
	always_comb begin
		next_st.meta = async_in;
		next_st.stable = st.meta;
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	assign sync_out = st.stable;
endmodule

// >>> rtl/blr_section_guard.sv
// Protection decision for one flash section from its two lock bits.
module blr_section_guard (
	input wire logic write_lock_bit,
	input wire logic read_lock_bit,
	input wire logic target_here,
	input wire logic exec_here,
	input wire logic vectors_elsewhere,
	output logic write_block,
	output logic read_block,
	output logic irq_block
);
	// A lock bit at zero is programmed and at one is unprogrammed.
	// With both bits at one nothing below blocks anything.
	always_comb begin
		write_block = target_here & ~write_lock_bit;
		read_block = target_here & ~exec_here & ~read_lock_bit;
		irq_block = exec_here & vectors_elsewhere & ~read_lock_bit;
	end
endmodule

// >>> bench/blr_core_model.sv
// Processor core model that issues program memory accesses to the block.
module blr_core_model (
	input wire logic sys_clk,
	input wire logic go,
	input wire logic st,
	input wire logic [blr_pkg::ADDR_W-1:0] tgt,
	input wire logic [blr_pkg::ADDR_W-1:0] pc_in,
	input wire blr_pkg::blr_acc_rsp_t acc_rsp,
	output blr_pkg::blr_acc_req_t acc_req,
	output logic last_denied,
	output logic last_grant,
	output int n_done
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		acc_req = '0;
		last_denied = 1'b0;
		last_grant = 1'b0;
		n_done = 0;
	end
	// The program counter is held between accesses, as a real core's would be.
	always @(posedge sys_clk) begin
		acc_req.valid <= go;
		acc_req.store <= st;
		acc_req.pc <= pc_in;
		// An idle target keeps changing so a stale address can never pass for a request.
		acc_req.target <= go ? tgt : ~acc_req.target;
		if (acc_rsp.done === 1'b1) begin
			last_denied <= acc_rsp.denied;
			last_grant <= acc_rsp.grant;
			n_done <= n_done + 1;
		end
	end
endmodule

// >>> bench/blr_top_tb.sv
// Self-checking testbench for the boot lock and reset vector block.
module blr_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] BOOT = 16'h1000;
	localparam logic [15:0] APP_A = 16'h0200;
	localparam logic [15:0] BOOT_A = 16'h1800;
	localparam logic [14:0] VCFG = {3'b111, 3'b101, 3'b100, 3'b011, 3'b110};
	localparam logic [4:0] VEXP = 5'b00110;
	localparam logic [27:0] LKS = {4'h7, 4'h3, 4'hB, 4'hD, 4'hC, 4'hE, 4'hF};
	localparam logic [27:0] DNY = {4'h1, 4'h5, 4'h4, 4'h2, 4'hA, 4'h8, 4'h0};
	logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, vectors_in_boot;
	logic irq_mask, hw_boot_pin, reset_vector_valid, go, st, last_denied, last_grant;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] tgt, pc_in, reset_vector;
	logic er;
	blr_pkg::blr_acc_req_t acc_req;
	blr_pkg::blr_acc_rsp_t acc_rsp;
	blr_pkg::blr_fuse_t fuses;
	blr_pkg::blr_prog_t ext_prog;
	int n_done, fails, checks;
	blr_top dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_req(acc_req), .acc_rsp(acc_rsp),
		.vectors_in_boot(vectors_in_boot), .irq_mask(irq_mask), .boot_start_addr(BOOT),
		.fuses(fuses), .ext_prog(ext_prog), .hw_boot_pin(hw_boot_pin),
		.reset_vector(reset_vector), .reset_vector_valid(reset_vector_valid));
	blr_core_model core (.sys_clk(sys_clk), .go(go), .st(st), .tgt(tgt), .pc_in(pc_in),
		.acc_rsp(acc_rsp), .acc_req(acc_req), .last_denied(last_denied),
		.last_grant(last_grant), .n_done(n_done));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			fails++;
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic acc(input logic s, input logic [15:0] t, input logic [15:0] p,
		input logic den);
		int n0, i;
		n0 = n_done;
		@(posedge sys_clk);
		go <= 1'b1;
		st <= s;
		tgt <= t;
		pc_in <= p;
		@(posedge sys_clk);
		go <= 1'b0;
		for (i = 0; i < 10 && n_done == n0; i++) @(posedge sys_clk);
		if (n_done == n0) begin
			fails++;
			conclude();
		end
		chk(last_denied, den);
		chk(last_grant, !den);
	endtask
	task automatic rst(input logic [2:0] c);
		@(posedge sys_clk);
		srst <= 1'b1;
		fuses <= c[2:1];
		hw_boot_pin <= c[0];
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic erase();
		@(posedge sys_clk);
		ext_prog.chip_erase <= 1'b1;
		@(posedge sys_clk);
		ext_prog.chip_erase <= 1'b0;
	endtask
	task automatic vector_table();
		for (int k = 0; k < 5; k++) begin
			rst(VCFG[3*k +: 3]);
			chk(reset_vector, VEXP[k] ? BOOT : 16'h0000);
			chk(reset_vector_valid, 1'b1);
			apb(1'b0, blr_pkg::OFF_VECTOR, 32'h0);
			chk(rd, {16'h0, VEXP[k] ? BOOT : 16'h0000});
			apb(1'b0, blr_pkg::OFF_STATUS, 32'h0);
			chk(rd, {27'h0, 1'b1, 3'b000, VEXP[k]});
			apb(1'b0, blr_pkg::OFF_FUSE, 32'h0);
			chk(rd, {29'h0, VCFG[3*k], VCFG[3*k+1], VCFG[3*k+2]});
		end
	endtask
	// Locks only ever clear, so every mode starts from a chip erase.
	task automatic lock_table();
		logic [3:0] lk, dn;
		for (int k = 0; k < 7; k++) begin
			lk = LKS[4*k +: 4];
			dn = DNY[4*k +: 4];
			erase();
			apb(1'b1, blr_pkg::OFF_LOCK, {28'h0, lk});
			apb(1'b1, blr_pkg::OFF_LOCK, 32'h0000_000F);
			apb(1'b0, blr_pkg::OFF_LOCK, 32'h0);
			chk(rd, {28'h0, lk});
			acc(1'b1, APP_A, BOOT_A, dn[3]);
			acc(1'b1, BOOT_A, BOOT_A, dn[2]);
			acc(1'b0, APP_A, BOOT_A, dn[1]);
			acc(1'b0, BOOT_A, APP_A, dn[0]);
			acc(1'b1, APP_A, APP_A, 1'b1);
			vectors_in_boot <= 1'b1;
			acc(1'b0, APP_A, APP_A, 1'b0);
			chk(irq_mask, !lk[1]);
			vectors_in_boot <= 1'b0;
			acc(1'b0, BOOT_A, BOOT_A, 1'b0);
			chk(irq_mask, !lk[3]);
		end
	endtask
	task automatic misc();
		apb(1'b0, 8'h10, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b0, blr_pkg::OFF_STATUS, 32'h0);
		chk(er, 1'b0);
		chk(rd, 32'h0000_001E);
		apb(1'b1, blr_pkg::OFF_STATUS, 32'h0000_0006);
		apb(1'b0, blr_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h0000_0018);
		apb(1'b1, blr_pkg::OFF_FUSE, 32'h0);
		apb(1'b0, blr_pkg::OFF_FUSE, 32'h0);
		chk(rd, 32'h0000_0007);
		erase();
		@(posedge sys_clk);
		ext_prog <= '{lock_we: 1'b1, lock_data: 4'h6, chip_erase: 1'b0};
		@(posedge sys_clk);
		ext_prog <= '0;
		apb(1'b0, blr_pkg::OFF_LOCK, 32'h0);
		chk(rd, 32'h0000_0006);
	endtask
	initial begin
		srst = 1'b1;
		{psel, penable, pwrite, go, st, vectors_in_boot} = '0;
		{paddr, pwdata, tgt, pc_in} = '0;
		fuses = 2'b11;
		ext_prog = '0;
		hw_boot_pin = 1'b1;
		fails = 0;
		checks = 0;
		vector_table();
		lock_table();
		misc();
		conclude();
	end
endmodule
